// ---- hw/rate_comp_pkg.sv ----
// Constants shared by the rate compensation block and its engine.
package rate_comp_pkg;
   localparam int RATE_W = 24;
   localparam int TEMP_W = 14;
   localparam int ACC_W = 48;
   localparam int DIFF_W = 21;
   localparam int NUM_REGS = 12;
   localparam int NUM_SLOTS = 5;
   localparam int TEMP_MUL_SHIFT = 6;
   localparam int SCALE0_FRAC = 27;
   localparam int OUT_SCALE = 10000;
   // Register indices; the byte address is four times the index.
   localparam logic [6:0] IDX_CTRL = 7'h3D;
   localparam logic [6:0] IDX_BIAS0 = 7'h3E;
   localparam logic [6:0] IDX_SCALE0 = 7'h3F;
   localparam logic [6:0] IDX_MIDPOINT = 7'h40;
   localparam logic [6:0] IDX_LAST = 7'h48;
   localparam logic [6:0] IDX_RATE = 7'h50;
   localparam logic [6:0] IDX_PROG = 7'h51;
   localparam logic [6:0] IDX_STATUS = 7'h52;
   localparam logic [6:0] IDX_SADDR = 7'h53;
   localparam logic [6:0] IDX_SDATA = 7'h54;
   localparam int SEL_BIT = 31;
   localparam int SLOT_LSB = 8;
   localparam int SLOT_MSB = 12;
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam logic [4:0] SLOT_FULL = 5'h1F;
   localparam logic [4:0] SLOT_DEFAULT = 5'h01;
   localparam logic [31:0] SCALE0_UNITY = 32'h0800_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Field widths by offset from IDX_CTRL: control, bias 0, scale 0, midpoint, then bias and scale of orders 1 to 4.
   localparam int FIELD_W [NUM_REGS] = '{32, 24, 31, 20, 30, 30, 20, 21, 20, 20, 19, 19};
   // Horner shifts when stepping from order i to order i-1, indexed by i.
   localparam int SF_SHIFT [5] = '{0, 19, 9, 17, 20};
   localparam int B_SHIFT [5] = '{0, 20, 12, 21, 20};
   typedef enum logic [2:0] {
      ENG_IDLE = 3'b000,
      ENG_SF = 3'b001,
      ENG_BIAS = 3'b010,
      ENG_SETUP = 3'b011,
      ENG_DIV = 3'b100,
      ENG_DONE = 3'b101
   } eng_state_t;
endpackage

// ---- hw/rate_comp_engine.sv ----
// Serial polynomial evaluator and divider producing one compensated rate.
`timescale 1ns/1ps
module rate_comp_engine
   import rate_comp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic start_in,
   input wire logic signed [RATE_W-1:0] rate_in,
   input wire logic [TEMP_W-1:0] temp_in,
   input wire logic [19:0] temp_midpoint_in,
   input wire logic signed [ACC_W-1:0] scale_coef_in [5],
   input wire logic signed [ACC_W-1:0] bias_coef_in [5],
   output logic busy_out,
   output logic done_out,
   output logic signed [RATE_W-1:0] comp_out
);
   localparam int NUM_W = ACC_W + 1 + SCALE0_FRAC;
   localparam logic signed [RATE_W-1:0] SAT_HI = {1'b0, {(RATE_W-1){1'b1}}};
   localparam logic signed [RATE_W-1:0] SAT_LO = {1'b1, {(RATE_W-1){1'b0}}};

   eng_state_t state;
   logic [2:0] order;
   logic [6:0] count;
   logic signed [DIFF_W-1:0] diff_t;
   logic signed [ACC_W-1:0] acc, sf_val;
   logic signed [RATE_W-1:0] rate_hold;
   logic [NUM_W-1:0] num, quo;
   logic [ACC_W:0] rem;
   logic [ACC_W-1:0] den;
   logic neg;
   wire signed [ACC_W+DIFF_W-1:0] prod = acc * diff_t;
   wire in_sf = (state == ENG_SF);
   wire [4:0] shift = 5'(in_sf ? SF_SHIFT[order] : B_SHIFT[order]);
   wire signed [ACC_W-1:0] step_term = ACC_W'(prod >>> shift);
   wire signed [ACC_W-1:0] next_coef = in_sf ? scale_coef_in[order - 3'd1] : bias_coef_in[order - 3'd1];
   wire signed [ACC_W:0] rate_diff = (ACC_W+1)'(rate_hold) - (ACC_W+1)'(acc);
   wire [ACC_W:0] rem_sh = {rem[ACC_W-1:0], num[NUM_W-1]};
   wire rem_ge = rem_sh >= {1'b0, den};
   wire quo_big = |quo[NUM_W-1:RATE_W-1];
   wire signed [RATE_W-1:0] quo_s = RATE_W'(quo);

   // Horner evaluation of both polynomials, then restoring division of (raw - bias) << 27 by the scale term.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         state <= ENG_IDLE;
         order <= 3'd0;
         count <= 7'd0;
         done_out <= 1'b0;
         busy_out <= 1'b0;
         comp_out <= '0;
      end else begin
         done_out <= 1'b0;
         case (state)
            ENG_IDLE: if (start_in) begin
               // Polynomial variable is temperature times 64 minus the midpoint.
               diff_t <= DIFF_W'({temp_in, {TEMP_MUL_SHIFT{1'b0}}}) - DIFF_W'({1'b0, temp_midpoint_in});
               rate_hold <= rate_in;
               acc <= scale_coef_in[4];
               order <= 3'd4;
               busy_out <= 1'b1;
               state <= ENG_SF;
            end
            ENG_SF, ENG_BIAS: begin
               acc <= next_coef + step_term;
               order <= order - 3'd1;
               if (order == 3'd1) begin
                  if (in_sf) begin
                     sf_val <= next_coef + step_term;
                     acc <= bias_coef_in[4];
                     order <= 3'd4;
                     state <= ENG_BIAS;
                  end else begin
                     state <= ENG_SETUP;
                  end
               end
            end
            ENG_SETUP: begin
               // Signs are split off so the divider works on magnitudes.
               neg <= rate_diff[ACC_W] ^ sf_val[ACC_W-1];
               num <= NUM_W'(rate_diff[ACC_W] ? -rate_diff : rate_diff) << SCALE0_FRAC;
               den <= sf_val[ACC_W-1] ? ACC_W'(-sf_val) : sf_val;
               rem <= '0;
               count <= 7'(NUM_W);
               state <= ENG_DIV;
            end
            ENG_DIV: begin
               rem <= rem_ge ? rem_sh - {1'b0, den} : rem_sh;
               quo <= {quo[NUM_W-2:0], rem_ge};
               num <= num << 1;
               count <= count - 7'd1;
               if (count == 7'd1) begin
                  state <= ENG_DONE;
               end
            end
            ENG_DONE: begin
               // A zero scale term or an oversize result saturates instead of wrapping.
               if (den == '0 || quo_big) begin
                  comp_out <= neg ? SAT_LO : SAT_HI;
               end else begin
                  comp_out <= neg ? -quo_s : quo_s;
               end
               done_out <= 1'b1;
               busy_out <= 1'b0;
               state <= ENG_IDLE;
            end
            default: state <= ENG_IDLE;
         endcase
      end
   end
endmodule

// ---- hw/rate_temp_compensation.sv ----
// Temperature compensation of the filtered rate, with coefficient registers and slot store.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module rate_temp_compensation
   import rate_comp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [8:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [8:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic signed [RATE_W-1:0] rate_raw_in,
   input wire logic rate_valid_in,
   input wire logic [TEMP_W-1:0] temp_raw_in,
   input wire logic factory_init_in,
   output logic signed [RATE_W-1:0] rate_out,
   output logic rate_valid_out
);
   // Output counts per degree per second assumed by the scale coefficients.
   localparam int OUTPUT_SCALE_CONSTANT = OUT_SCALE;

   logic [31:0] sysreg [NUM_REGS];
   logic [31:0] store_mem [NUM_SLOTS][NUM_REGS];
   logic [NUM_REGS-1:0] store_done [NUM_SLOTS];
   logic [4:0] store_slot;
   logic store_sel;
   logic reload_pending;
   logic refused;
   logic [6:0] store_addr;
   logic [8:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_held, w_held;
   logic signed [RATE_W-1:0] pend_rate, last_comp;
   logic signed [RATE_W-1:0] pend_hold;
   logic [TEMP_W-1:0] pend_temp;
   logic pend_valid;
   logic signed [ACC_W-1:0] sf_coef [5];
   logic signed [ACC_W-1:0] b_coef [5];
   logic signed [RATE_W-1:0] eng_comp;
   logic eng_busy, eng_done;

   // Ones count of the thermometer slot code; a broken code counts as full so nothing more is taken.
   function automatic logic [2:0] slot_ones(input logic [4:0] code);
      case (code)
         5'h00: slot_ones = 3'd0;
         5'h01: slot_ones = 3'd1;
         5'h03: slot_ones = 3'd2;
         5'h07: slot_ones = 3'd3;
         5'h0F: slot_ones = 3'd4;
         default: slot_ones = 3'd5;
      endcase
   endfunction

   // Value held by the unprogrammed device at a register offset: unity scale, zero bias.
   function automatic logic [31:0] unity_word(input int k);
      unity_word = (k == int'(IDX_SCALE0 - IDX_CTRL)) ? SCALE0_UNITY : '0;
   endfunction

   // Write and read decode on word indices.
   wire [6:0] w_idx = aw_addr[8:2];
   wire [6:0] r_idx = s_axi_araddr_in[8:2];
   wire w_is_sys = (w_idx >= IDX_CTRL) && (w_idx <= IDX_LAST);
   wire r_is_sys = (r_idx >= IDX_CTRL) && (r_idx <= IDX_LAST);
   wire [3:0] w_off = 4'(w_idx - IDX_CTRL);
   wire [3:0] r_off = 4'(r_idx - IDX_CTRL);
   wire w_mapped = w_is_sys || w_idx == IDX_PROG || w_idx == IDX_STATUS || w_idx == IDX_SADDR;
   wire r_mapped = r_is_sys || (r_idx >= IDX_RATE && r_idx <= IDX_SDATA);
   wire do_write = aw_held && w_held && !s_axi_bvalid_out;
   wire do_read = s_axi_arvalid_in && s_axi_arready_out;
   wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire s_axi_bvalid_in_ack = s_axi_bvalid_out && s_axi_bready_in;

   // Store programming: the target register index comes in the data of a write to the program register.
   wire prog_hit = do_write && w_idx == IDX_PROG;
   wire [6:0] prog_idx = w_data[6:0];
   wire prog_sys = (prog_idx >= IDX_CTRL) && (prog_idx <= IDX_LAST);
   wire [3:0] prog_off = 4'(prog_idx - IDX_CTRL);
   wire prog_ctrl = prog_idx == IDX_CTRL;
   wire [2:0] used_slots = slot_ones(store_slot);
   wire [4:0] next_code = {store_slot[3:0], 1'b1};
   wire [4:0] new_code = sysreg[0][SLOT_MSB:SLOT_LSB];
   wire slot_ok = store_slot != SLOT_FULL && new_code == next_code && used_slots != 3'd5;
   wire coef_ok = used_slots < 3'd5 && !store_done[used_slots][prog_off];
   wire prog_ok = prog_sys && (prog_ctrl ? slot_ok : coef_ok);
   wire prog_bad = prog_hit && !prog_ok;

   // Active slot is the last one sealed by a counter advance; zero slots means unity defaults.
   wire [2:0] act_slot = used_slots - 3'd1;
   wire s_is_sys = (store_addr >= IDX_CTRL) && (store_addr <= IDX_LAST);
   wire [3:0] s_off = 4'(store_addr - IDX_CTRL);
   wire [31:0] s_ctrl_word = {store_sel, 18'h0_0000, store_slot, 8'h00};
   wire [31:0] s_coef_word = used_slots == 3'd0 ? unity_word(int'(s_off)) : store_mem[act_slot][s_off];
   wire [31:0] s_word = !s_is_sys ? 32'h0000_0000 : (s_off == 4'h0 ? s_ctrl_word : s_coef_word);
   wire [31:0] status_word = {19'h0_0000, store_slot, 6'h00, refused, eng_busy};
   wire [31:0] read_mux = r_is_sys ? sysreg[r_off] :
      r_idx == IDX_RATE ? 32'(last_comp) :
      r_idx == IDX_STATUS ? status_word :
      r_idx == IDX_SADDR ? {25'h000_0000, store_addr} :
      r_idx == IDX_SDATA ? s_word : 32'h0000_0000;

   // Coefficient fields sign-extended to the accumulator width; upper bits of each word are ignored.
   assign sf_coef[0] = ACC_W'($signed(sysreg[2][FIELD_W[2]-1:0]));
   assign sf_coef[1] = ACC_W'($signed(sysreg[5][FIELD_W[5]-1:0]));
   assign sf_coef[2] = ACC_W'($signed(sysreg[7][FIELD_W[7]-1:0]));
   assign sf_coef[3] = ACC_W'($signed(sysreg[9][FIELD_W[9]-1:0]));
   assign sf_coef[4] = ACC_W'($signed(sysreg[11][FIELD_W[11]-1:0]));
   assign b_coef[0] = ACC_W'($signed(sysreg[1][FIELD_W[1]-1:0]));
   assign b_coef[1] = ACC_W'($signed(sysreg[4][FIELD_W[4]-1:0]));
   assign b_coef[2] = ACC_W'($signed(sysreg[6][FIELD_W[6]-1:0]));
   assign b_coef[3] = ACC_W'($signed(sysreg[8][FIELD_W[8]-1:0]));
   assign b_coef[4] = ACC_W'($signed(sysreg[10][FIELD_W[10]-1:0]));

   // AXI write channels: address and data are caught independently, then answered together.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
      end else begin
         s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out);
         s_axi_wready_out <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out);
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= w_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_in_ack) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // AXI read channel: one read at a time, answered the cycle after the address is taken.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (do_read) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= read_mux;
         s_axi_rresp_out <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end else if (!s_axi_rvalid_out) begin
         s_axi_arready_out <= 1'b1;
      end
   end

   // System registers: cleared by reset, then reloaded from the store in the next cycle.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         reload_pending <= 1'b1;
         store_addr <= IDX_CTRL;
         for (int k = 0; k < NUM_REGS; k++) begin
            sysreg[k] <= '0;
         end
      end else if (reload_pending) begin
         reload_pending <= 1'b0;
         // Calibrated output select and slot count come back from the store.
         sysreg[0] <= s_ctrl_word;
         for (int k = 1; k < NUM_REGS; k++) begin
            sysreg[k] <= used_slots == 3'd0 ? unity_word(k) : store_mem[act_slot][k];
         end
      end else if (do_write) begin
         if (w_is_sys) begin
            sysreg[w_off] <= (sysreg[w_off] & ~byte_mask) | (w_data & byte_mask);
         end
         if (w_idx == IDX_SADDR && w_strb[0]) begin
            store_addr <= w_data[6:0];
         end
      end
   end

   // Refused programming is sticky; a new refusal wins over a clear written in the same cycle.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         refused <= 1'b0;
      end else if (prog_bad) begin
         refused <= 1'b1;
      end else if (do_write && w_idx == IDX_STATUS && w_strb[0] && w_data[ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // Non-volatile store: untouched by reset, each word of each slot written once.
   always_ff @(posedge core_clk_in) begin
      if (factory_init_in) begin
         store_slot <= SLOT_DEFAULT;
         store_sel <= 1'b1;
         for (int s = 0; s < NUM_SLOTS; s++) begin
            store_done[s] <= '0;
            for (int k = 0; k < NUM_REGS; k++) begin
               store_mem[s][k] <= (s == 0) ? unity_word(k) : '0;
            end
         end
      end else if (prog_hit && prog_ok) begin
         if (prog_ctrl) begin
            store_slot <= new_code;
            store_sel <= sysreg[0][SEL_BIT];
         end else begin
            store_mem[used_slots][prog_off] <= sysreg[prog_off];
            store_done[used_slots][prog_off] <= 1'b1;
         end
      end
   end

   // A sample that arrives while the engine is busy waits here; a newer one replaces it.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         pend_valid <= 1'b0;
      end else if (rate_valid_in) begin
         pend_valid <= 1'b1;
         pend_rate <= rate_raw_in;
         pend_temp <= temp_raw_in;
      end else if (!eng_busy && !reload_pending) begin
         pend_valid <= 1'b0;
      end
   end

   rate_comp_engine u_engine (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .start_in(pend_valid && !eng_busy && !reload_pending),
      .rate_in(pend_rate),
      .temp_in(pend_temp),
      .temp_midpoint_in(sysreg[3][FIELD_W[3]-1:0]),
      .scale_coef_in(sf_coef),
      .bias_coef_in(b_coef),
      .busy_out(eng_busy),
      .done_out(eng_done),
      .comp_out(eng_comp)
   );

   // Raw passes through the same pipeline so both selections share one latency.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rate_out <= '0;
         rate_valid_out <= 1'b0;
         last_comp <= '0;
      end else begin
         rate_valid_out <= eng_done;
         if (eng_done) begin
            last_comp <= eng_comp;
            rate_out <= sysreg[0][SEL_BIT] ? eng_comp : pend_hold;
         end
      end
   end

   // Copy of the raw sample the engine is working on.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         pend_hold <= '0;
      end else if (pend_valid && !eng_busy && !reload_pending) begin
         pend_hold <= pend_rate;
      end
   end
endmodule

// ---- testbench/rate_comp_sva.sv ----
// Port checker for the rate compensation block, bound into every instance.
`timescale 1ns/1ps
module rate_comp_sva (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic rate_valid_in,
   input wire logic rate_valid_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // A write is complete once address and data were taken on one edge.
   sequence s_both_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid_out)
      else $error("write not answered");
   a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   a_write_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while answering");
   a_read_answer: assert property (s_read_taken |=> s_axi_rvalid_out)
      else $error("read not answered in one cycle");
   a_rdata_held: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data changed while waiting");
   a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read taken while answering");
   a_sample_answer: assert property (rate_valid_in |-> ##[1:200] rate_valid_out)
      else $error("sample never produced a result");
   a_output_strobe: assert property (rate_valid_out |=> !rate_valid_out)
      else $error("result strobe longer than one cycle");
endmodule
bind rate_temp_compensation rate_comp_sva i_sva (.*);

// ---- testbench/host_model.sv ----
// Bus master model of the host that programs the compensation block.
`timescale 1ns/1ps
module host_model
   import rate_comp_pkg::*;
(
   input wire logic clk_in,
   output logic [8:0] awaddr_out,
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [31:0] wdata_out,
   output logic wvalid_out,
   input wire logic wready_in,
   input wire logic bvalid_in,
   output logic bready_out,
   output logic [8:0] araddr_out,
   output logic arvalid_out,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in,
   output logic rready_out
);
   // The bus idles until a task offers something.
   initial begin
      {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
      {awaddr_out, araddr_out, wdata_out} = '0;
   end
   // Address and data go out together; each drops once taken, so neither is offered twice.
   task automatic write_reg(input logic [6:0] idx, input logic [31:0] data);
      @(posedge clk_in);
      awaddr_out <= {idx, 2'b00};
      wdata_out <= data;
      {awvalid_out, wvalid_out, bready_out} <= 3'h7;
      do begin
         @(posedge clk_in);
         if (awready_in) awvalid_out <= 1'b0;
         if (wready_in) wvalid_out <= 1'b0;
      end while (!bvalid_in);
      bready_out <= 1'b0;
   endtask
   task automatic read_reg(input logic [6:0] idx, output logic [31:0] data, output logic [1:0] resp);
      @(posedge clk_in);
      araddr_out <= {idx, 2'b00};
      {arvalid_out, rready_out} <= 2'h3;
      do begin
         @(posedge clk_in);
         if (arready_in) arvalid_out <= 1'b0;
      end while (!rvalid_in);
      data = rdata_in;
      resp = rresp_in;
      rready_out <= 1'b0;
   endtask
   // A value reaches the store only after it sits in the working register.
   task automatic program_word(input logic [6:0] idx, input logic [31:0] data);
      write_reg(idx, data);
      write_reg(IDX_PROG, {25'h0, idx});
   endtask
   // The slot count moves one thermometer step; the select bit is kept as read.
   task automatic advance_slot();
      logic [31:0] ctrl;
      logic [1:0] resp;
      read_reg(IDX_CTRL, ctrl, resp);
      ctrl[SLOT_MSB:SLOT_LSB] = {ctrl[SLOT_MSB-1:SLOT_LSB], 1'b1};
      program_word(IDX_CTRL, ctrl);
   endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the rate compensation block.
`timescale 1ns/1ps
module testbench;
   import rate_comp_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, init = 1'b1, rvin = 1'b0;
   logic signed [RATE_W-1:0] raw = '0, rate;
   logic [TEMP_W-1:0] temp = '0;
   logic [8:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, vout;
   int mismatches = 0, checks_done = 0;
   int exp_q[$];
   logic [6:0] order [11] = '{7'h48, 7'h46, 7'h44, 7'h42, 7'h3F, 7'h47, 7'h45, 7'h43, 7'h41, 7'h3E, 7'h40};
   logic [31:0] vals [11] = '{0, 0, 0, 0, 32'h0400_0000, 0, 0, 0, 32'h0010_0000, 32'h64, 32'h100};
   // Period of 40 ns.
   always #20 clk = ~clk;
   rate_temp_compensation i_dut (.core_clk_in(clk), .resetn_in(resetn), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(br), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
      .rate_raw_in(raw), .rate_valid_in(rvin), .temp_raw_in(temp), .factory_init_in(init),
      .rate_out(rate), .rate_valid_out(vout));
   host_model i_host (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awv), .awready_in(awr), .wdata_out(wdata),
      .wvalid_out(wv), .wready_in(wr), .bvalid_in(bv), .bready_out(br), .araddr_out(araddr), .arvalid_out(arv),
      .arready_in(arr), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rv), .rready_out(rr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rdc(input logic [6:0] idx, input logic [31:0] mask, input logic [31:0] exp);
      i_host.read_reg(idx, rd, rs);
      check(rd & mask, exp);
   endtask
   // The store survives reset, so the first reset also carries the factory erase.
   task automatic apply_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      init <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // One random sample; bias has a first-order coefficient of 1.0, a constant of 100 and a midpoint of 256.
   task automatic sample(input int mul, input bit use_bias);
      int t;
      int r;
      t = int'($urandom_range(255));
      r = int'($urandom_range(1048575)) - 524288;
      @(posedge clk);
      temp <= t[TEMP_W-1:0];
      raw <= r[RATE_W-1:0];
      rvin <= 1'b1;
      exp_q.push_back(mul * (r - (use_bias ? t * 64 - 256 + 100 : 0)));
      @(posedge clk);
      rvin <= 1'b0;
      while (exp_q.size() != 0) @(posedge clk);
   endtask
   // Each result is matched against the oldest queued expectation; an unasked result meets a value it cannot show.
   always @(posedge clk) begin
      if (vout === 1'b1) check(32'(rate), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hFF00_0000);
   end
   initial begin
      void'($urandom(32'hCC55));
      apply_reset();
      apply_reset();
      rdc(IDX_CTRL, 32'hFFFF_FFFF, 32'h8000_0100);
      rdc(IDX_SCALE0, 32'hFFFF_FFFF, SCALE0_UNITY);
      rdc(7'h00, 32'hFFFF_FFFF, 32'h0);
      check(rs, RESP_SLVERR);
      i_host.write_reg(7'h00, 32'h0);
      check(bresp, RESP_SLVERR);
      repeat (3) sample(1, 0);
      $display("defaults done");
      i_host.write_reg(IDX_BIAS0, 32'h64);
      i_host.write_reg(7'h41, 32'h0010_0000);
      i_host.write_reg(IDX_MIDPOINT, 32'h100);
      i_host.write_reg(IDX_SCALE0, 32'h0400_0000);
      check(bresp, RESP_OKAY);
      repeat (3) sample(2, 1);
      i_host.write_reg(IDX_CTRL, 32'h0000_0100);
      repeat (2) sample(1, 0);
      i_host.write_reg(IDX_CTRL, 32'h8000_0100);
      $display("compensation done");
      foreach (order[i]) i_host.program_word(order[i], vals[i]);
      i_host.advance_slot();
      i_host.write_reg(IDX_SCALE0, SCALE0_UNITY);
      apply_reset();
      rdc(IDX_SCALE0, 32'hFFFF_FFFF, 32'h0400_0000);
      rdc(IDX_CTRL, 32'hFFFF_FFFF, 32'h8000_0300);
      repeat (2) sample(2, 1);
      $display("programming done");
      i_host.write_reg(IDX_CTRL, 32'h8000_0F00);
      i_host.write_reg(IDX_PROG, {25'h0, IDX_CTRL});
      rdc(IDX_STATUS, 32'h1F02, 32'h0302);
      i_host.write_reg(IDX_STATUS, 32'h2);
      i_host.write_reg(IDX_CTRL, 32'h8000_0300);
      repeat (3) i_host.advance_slot();
      rdc(IDX_STATUS, 32'h1F02, 32'h1F00);
      i_host.write_reg(IDX_PROG, {25'h0, IDX_CTRL});
      rdc(IDX_STATUS, 32'h1F02, 32'h1F02);
      $display("slot counter done");
      complete_run();
   end
   // A hang ends the run through the same closing path.
   initial begin
      #(40 * 20000);
      mismatches++;
      complete_run();
   end
endmodule
